/* hdl/wwt_window_watchdog.sv */
module wwt_window_watchdog #(
	parameter int WDOG_DIV = wwt_pkg::WDOG_DIV_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic por_rst,
	input wwt_pkg::wwt_bus_req_t bus_req,
	output logic [31:0] bus_rdata,
	input wire logic cpu_debug_halt,
	output logic sys_reset_req,
	output logic irq
);

	logic wd_tick;
	logic halt_s1_r, halt_s2_r, halt_s3_r, halted_r;
	logic ctl_dbg_r, ctl_irqen_r, ctl_en_r, ctl_locked_r;
	logic [5:0] ctl_cmp_r;
	logic [3:0] ctl_psc_r;
	logic [10:0] psc_cnt_r;
	logic [5:0] cnt_r;
	logic [5:0] cnt_dec;
	wwt_pkg::wwt_rf_state_t rf_state_r;
	logic match_flag_r, irq_flag_r, rst_flag_r;
	logic [2:0] mask_r;
	logic [2:0] status;
	logic reset_req_r, irq_r;
	logic [31:0] rdata_r;
	logic count_tick, dec_evt, reload_evt, match_evt;
	logic refresh_wr, key_wr, bad_window, ctl_wr, st_wr, mask_wr;
	logic [1:0] rf_ticks_r; // check-only tick count since the last accepted key
	// last tick index of the refresh sync, counted from zero
	localparam logic [1:0] RF_LAST = 2'(wwt_pkg::SYNC_TICKS - 1);

	////////////////////////////////////////////////////////////////////////
	// watchdog clock as an enable pulse
	wwt_tick_div #(
		.DIV(WDOG_DIV)
	) u_tick (
		.clk(clk),
		.rst(rst),
		.tick_r(wd_tick)
	);

	// debug halt comes from another domain: three stages, accept on agreement
	always_ff @(posedge clk) begin
		if (rst) begin
			halt_s1_r <= 1'b0;
			halt_s2_r <= 1'b0;
			halt_s3_r <= 1'b0;
			halted_r <= 1'b0;
		end else begin
			halt_s1_r <= cpu_debug_halt;
			halt_s2_r <= halt_s1_r;
			halt_s3_r <= halt_s2_r;
			if (halt_s2_r == halt_s3_r) begin
				halted_r <= halt_s3_r;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bus decode
	assign refresh_wr = bus_req.wr && (bus_req.addr == wwt_pkg::OFF_REFRESH);
	assign ctl_wr = bus_req.wr && (bus_req.addr == wwt_pkg::OFF_CONTROL);
	assign st_wr = bus_req.wr && (bus_req.addr == wwt_pkg::OFF_STATUS);
	assign mask_wr = bus_req.wr && (bus_req.addr == wwt_pkg::OFF_MASK);
	// only the exact key counts; anything else falls through untouched
	assign key_wr = refresh_wr && ctl_en_r && (bus_req.wdata == wwt_pkg::REFRESH_KEY);
	assign bad_window = key_wr && (cnt_r > ctl_cmp_r);

	// control: one write only, guards against runaway code turning us off
	always_ff @(posedge clk) begin
		if (rst) begin
			ctl_dbg_r <= wwt_pkg::CTL_RESET[wwt_pkg::CTL_DEBUG_BIT];
			ctl_cmp_r <= wwt_pkg::CTL_RESET[wwt_pkg::CTL_CMP_MSB:wwt_pkg::CTL_CMP_LSB];
			ctl_psc_r <= wwt_pkg::CTL_RESET[wwt_pkg::CTL_PSC_MSB:wwt_pkg::CTL_PSC_LSB];
			ctl_irqen_r <= wwt_pkg::CTL_RESET[wwt_pkg::CTL_IRQEN_BIT];
			ctl_en_r <= wwt_pkg::CTL_RESET[wwt_pkg::CTL_EN_BIT];
			ctl_locked_r <= 1'b0;
		end else if (ctl_wr && !ctl_locked_r) begin
			ctl_dbg_r <= bus_req.wdata[wwt_pkg::CTL_DEBUG_BIT];
			ctl_cmp_r <= bus_req.wdata[wwt_pkg::CTL_CMP_MSB:wwt_pkg::CTL_CMP_LSB];
			ctl_psc_r <= bus_req.wdata[wwt_pkg::CTL_PSC_MSB:wwt_pkg::CTL_PSC_LSB];
			ctl_irqen_r <= bus_req.wdata[wwt_pkg::CTL_IRQEN_BIT];
			ctl_en_r <= bus_req.wdata[wwt_pkg::CTL_EN_BIT];
			ctl_locked_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// counting
	// a halt only freezes counting when the ignore bit is clear
	assign count_tick = wd_tick && ctl_en_r && (ctl_dbg_r || !halted_r);
	assign dec_evt = count_tick && (psc_cnt_r == wwt_pkg::PSC_TERM[ctl_psc_r]);
	assign reload_evt = wd_tick && (rf_state_r == wwt_pkg::RF_SYNC3);
	assign cnt_dec = cnt_r - 6'h01;
	assign match_evt = dec_evt && (cnt_r != 6'h00) && (cnt_dec == ctl_cmp_r);

	// prescaler restarts with each reload so the full window is given back
	always_ff @(posedge clk) begin
		if (rst || reload_evt) begin
			psc_cnt_r <= '0;
		end else if (dec_evt) begin
			psc_cnt_r <= '0;
		end else if (count_tick) begin
			psc_cnt_r <= psc_cnt_r + 11'h001;
		end
	end

	// refresh handshake: three watchdog ticks from key write to reload
	always_ff @(posedge clk) begin
		if (rst) begin
			rf_state_r <= wwt_pkg::RF_IDLE;
		end else if (key_wr && !bad_window) begin
			rf_state_r <= wwt_pkg::RF_SYNC1;
		end else if (wd_tick) begin
			case (rf_state_r)
				wwt_pkg::RF_SYNC1: rf_state_r <= wwt_pkg::RF_SYNC2;
				wwt_pkg::RF_SYNC2: rf_state_r <= wwt_pkg::RF_SYNC3;
				wwt_pkg::RF_SYNC3: rf_state_r <= wwt_pkg::RF_IDLE;
				default: rf_state_r <= wwt_pkg::RF_IDLE;
			endcase
		end
	end

	// down counter: reload beats decrement, sticks at zero
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_r <= wwt_pkg::CNT_TOP;
		end else if (reload_evt) begin
			cnt_r <= wwt_pkg::CNT_TOP;
		end else if (dec_evt && cnt_r != 6'h00) begin
			cnt_r <= cnt_dec;
		end
	end

	// reset request holds until the system reset comes back to us
	always_ff @(posedge clk) begin
		if (rst) begin
			reset_req_r <= 1'b0;
		end else if (ctl_en_r && cnt_r == 6'h00) begin
			reset_req_r <= 1'b1;
		end else if (bad_window) begin
			reset_req_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status flags, set wins over a clearing write in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			match_flag_r <= wwt_pkg::STATUS_RESET[wwt_pkg::ST_MATCH_BIT];
		end else if (match_evt) begin
			match_flag_r <= 1'b1;
		end else if (st_wr && bus_req.wdata[wwt_pkg::ST_MATCH_BIT]) begin
			match_flag_r <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irq_flag_r <= wwt_pkg::STATUS_RESET[wwt_pkg::ST_IRQF_BIT];
		end else if (match_evt && ctl_irqen_r) begin
			irq_flag_r <= 1'b1;
		end else if (st_wr && bus_req.wdata[wwt_pkg::ST_IRQF_BIT]) begin
			irq_flag_r <= 1'b0;
		end
	end

	// no reset but power-on clears this one; the reset we cause must not erase it
	always_ff @(posedge clk) begin
		if (por_rst) begin
			rst_flag_r <= wwt_pkg::STATUS_RESET[wwt_pkg::ST_RSTF_BIT];
		end else if (rst && reset_req_r) begin
			rst_flag_r <= 1'b1;
		end else if (st_wr && bus_req.wdata[wwt_pkg::ST_RSTF_BIT]) begin
			rst_flag_r <= 1'b0;
		end
	end

	assign status = {match_flag_r, rst_flag_r, irq_flag_r};

	// interrupt mask, same layout as status
	always_ff @(posedge clk) begin
		if (rst) begin
			mask_r <= wwt_pkg::MASK_RESET;
		end else if (mask_wr) begin
			mask_r <= bus_req.wdata[wwt_pkg::ST_W-1:0];
		end
	end

	// level interrupt, one cycle behind the flags
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(status & mask_r);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read port: data valid only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (rst || !bus_req.rd) begin
			rdata_r <= 32'h0000_0000;
		end else begin
			case (bus_req.addr)
				wwt_pkg::OFF_CONTROL: rdata_r <= {ctl_dbg_r, 9'h000, ctl_cmp_r, 4'h0,
					ctl_psc_r, 6'h00, ctl_irqen_r, ctl_en_r};
				wwt_pkg::OFF_STATUS: rdata_r <= {29'h0, status};
				wwt_pkg::OFF_COUNT: rdata_r <= {26'h0, cnt_r};
				wwt_pkg::OFF_MASK: rdata_r <= {29'h0, mask_r};
				default: rdata_r <= 32'h0000_0000; // refresh is write-only
			endcase
		end
	end

	assign bus_rdata = rdata_r;
	assign sys_reset_req = reset_req_r;
	assign irq = irq_r;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// ticks since an accepted key, kept apart from the handshake so the reload
	// timing is judged independently; saturates at 3 when nothing is pending
	always_ff @(posedge clk) begin
		if (rst) begin
			rf_ticks_r <= 2'h3;
		end else if (key_wr && !bad_window) begin
			rf_ticks_r <= 2'h0;
		end else if (wd_tick && rf_ticks_r != 2'h3) begin
			rf_ticks_r <= rf_ticks_r + 2'h1;
		end
	end

	reload_after_sync_a: assert property (
		wd_tick && rf_ticks_r == RF_LAST && !key_wr |=> cnt_r == wwt_pkg::CNT_TOP)
		else $error("refresh never reloaded the counter");

	sync_three_ticks_a: assert property (
		reload_evt |-> rf_ticks_r == RF_LAST && wd_tick)
		else $error("reload without the full sync");

	bad_window_a: assert property (
		key_wr && (cnt_r > ctl_cmp_r) |=> sys_reset_req)
		else $error("refresh outside window did not request reset");

	halt_freeze_a: assert property (
		halted_r && !ctl_dbg_r && !reload_evt |=> $stable(cnt_r))
		else $error("counter moved during debug halt");

	stopped_a: assert property (
		!ctl_en_r |=> cnt_r == wwt_pkg::CNT_TOP && psc_cnt_r == 11'h000)
		else $error("counter moved while disabled");

	prescale_period_a: assert property (
		count_tick && !reload_evt && psc_cnt_r < wwt_pkg::PSC_TERM[ctl_psc_r]
			|=> $stable(cnt_r) && psc_cnt_r == $past(psc_cnt_r) + 11'h001)
		else $error("decrement off the prescale boundary");

	match_flags_a: assert property (
		match_evt |=> match_flag_r && (irq_flag_r == $past(ctl_irqen_r) || $past(irq_flag_r)))
		else $error("compare match flags wrong");

	zero_reset_a: assert property (
		ctl_en_r && cnt_r == 6'h00 |=> sys_reset_req)
		else $error("zero count did not request reset");

	ctl_lock_a: assert property (
		ctl_locked_r && ctl_wr |=> $stable(ctl_cmp_r) && $stable(ctl_psc_r) && $stable(ctl_en_r))
		else $error("control changed after lock");

	bad_key_a: assert property (
		refresh_wr && bus_req.wdata != wwt_pkg::REFRESH_KEY && rf_state_r == wwt_pkg::RF_IDLE
			&& !(ctl_en_r && cnt_r == 6'h00) && !sys_reset_req
			|=> rf_state_r == wwt_pkg::RF_IDLE && !sys_reset_req)
		else $error("wrong key had an effect");

	count_view_a: assert property (
		bus_req.rd && bus_req.addr == wwt_pkg::OFF_COUNT |=> bus_rdata == {26'h0, $past(cnt_r)})
		else $error("count read mismatch");

	reset_flag_keep_a: assert property (@(posedge clk) disable iff (por_rst)
		rst && reset_req_r |=> status[wwt_pkg::ST_RSTF_BIT])
		else $error("watchdog reset flag lost");

	prescale_bound_a: assert property (
		psc_cnt_r <= wwt_pkg::PSC_TERM[ctl_psc_r])
		else $error("prescaler ran past its period");

	irq_raise_a: assert property (
		(status & mask_r) != 3'h0 |=> irq)
		else $error("unmasked flag without interrupt");

	irq_quiet_a: assert property (
		(status & mask_r) == 3'h0 |=> !irq)
		else $error("interrupt with no unmasked flag");

	count_hold_zero_a: assert property (
		cnt_r == 6'h00 && !reload_evt |=> cnt_r == 6'h00)
		else $error("count left zero without reload");

	count_step_a: assert property (
		dec_evt && !reload_evt && cnt_r != 6'h00 |=> cnt_r == $past(cnt_r) - 6'h01)
		else $error("count did not step down by one");

	reset_req_hold_a: assert property (
		sys_reset_req |=> sys_reset_req)
		else $error("reset request dropped before reset");

	window_ok_a: assert property (
		key_wr && cnt_r <= ctl_cmp_r && cnt_r != 6'h00 && !sys_reset_req |=> !sys_reset_req)
		else $error("in-window refresh requested reset");

	key_off_a: assert property (
		refresh_wr && !ctl_en_r |=> rf_state_r == wwt_pkg::RF_IDLE && !sys_reset_req)
		else $error("refresh acted while disabled");

endmodule

/* hdl/wwt_pkg.sv */
package wwt_pkg;

	// clock periods, both times in nanoseconds
	localparam int CLK_PERIOD_NS = 5;
	localparam int WDOG_CLK_PERIOD_NS = 31250; // 32 kHz watchdog clock
	localparam int WDOG_DIV_CYCLES = WDOG_CLK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int SYNC_TICKS = 3; // watchdog clocks from refresh write to reload

	////////////////////////////////////////////////////////////////////////
	// register map
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_REFRESH = 8'h00;
	localparam logic [7:0] OFF_CONTROL = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_COUNT = 8'h0c;
	localparam logic [7:0] OFF_MASK = 8'h10;

	// field positions
	localparam int CTL_DEBUG_BIT = 31;
	localparam int CTL_CMP_MSB = 21;
	localparam int CTL_CMP_LSB = 16;
	localparam int CTL_PSC_MSB = 11;
	localparam int CTL_PSC_LSB = 8;
	localparam int CTL_IRQEN_BIT = 1;
	localparam int CTL_EN_BIT = 0;
	localparam int ST_MATCH_BIT = 2;
	localparam int ST_RSTF_BIT = 1;
	localparam int ST_IRQF_BIT = 0;
	localparam int ST_W = 3;

	// values
	localparam logic [31:0] REFRESH_KEY = 32'h0000_5aa5;
	localparam logic [5:0] CNT_TOP = 6'h3f;
	localparam logic [31:0] CTL_RESET = 32'h003f_0800;
	localparam logic [2:0] STATUS_RESET = 3'h0;
	localparam logic [2:0] MASK_RESET = 3'h0;

	// prescale period minus one, indexed by prescale_select
	localparam logic [10:0] PSC_TERM [16] = '{
		11'h000, 11'h001, 11'h003, 11'h007, 11'h00f, 11'h01f, 11'h03f, 11'h07f,
		11'h0bf, 11'h0ff, 11'h17f, 11'h1ff, 11'h2ff, 11'h3ff, 11'h5ff, 11'h7ff
	};

	////////////////////////////////////////////////////////////////////////
	// types
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} wwt_bus_req_t;

	typedef enum logic [1:0] {
		RF_IDLE,
		RF_SYNC1,
		RF_SYNC2,
		RF_SYNC3
	} wwt_rf_state_t;

endpackage

/* hdl/wwt_tick_div.sv */
// one-cycle enable pulse every DIV clocks, stands in for the watchdog clock
module wwt_tick_div #(
	parameter int DIV = 6250
) (
	input wire logic clk,
	input wire logic rst,
	output logic tick_r
);

	localparam int CW = (DIV > 2) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] TERM = CW'(DIV - 1);

	logic [CW-1:0] cnt_r;

	// free-running divider, never gated so refresh sync keeps moving
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_r <= '0;
			tick_r <= 1'b0;
		end else if (cnt_r == TERM) begin
			cnt_r <= '0;
			tick_r <= 1'b1;
		end else begin
			cnt_r <= cnt_r + CW'(1);
			tick_r <= 1'b0;
		end
	end

endmodule

/* test/test_window_watchdog_timer.sv */
module test_window_watchdog_timer;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk = 1'b0;
	logic rst = 1'b1;
	logic por_rst = 1'b1;
	logic cpu_debug_halt = 1'b0;
	wwt_pkg::wwt_bus_req_t bus_req = '0;
	logic [31:0] bus_rdata;
	logic sys_reset_req;
	logic irq;
	int n_mismatch = 0;
	int n_tests = 0;
	logic [31:0] v;
	logic [31:0] w;
	int n;

	// short tick divider keeps a full run-down to a few hundred cycles
	wwt_window_watchdog #(.WDOG_DIV(4)) DUT (
		.clk(clk),
		.rst(rst),
		.por_rst(por_rst),
		.bus_req(bus_req),
		.bus_rdata(bus_rdata),
		.cpu_debug_halt(cpu_debug_halt),
		.sys_reset_req(sys_reset_req),
		.irq(irq)
	);

	// free running clock, 5 ns period
	always #2.5 clk = ~clk;

	////////////////////////////////////////////////////////////////////////
	// helpers
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task cycles(input int k);
		repeat (k) @(posedge clk);
	endtask

	// each access ends one edge late so the strobe never gets two drives at once
	task wr(input logic [7:0] a, input logic [31:0] d);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus_req <= '0;
		@(posedge clk);
	endtask

	task rd(input logic [7:0] a, output logic [31:0] d);
		bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus_req <= '0;
		#1 d = bus_rdata;
		@(posedge clk);
	endtask

	task do_reset();
		rst <= 1'b1;
		cycles(12);
		rst <= 1'b0;
		@(posedge clk);
	endtask

	// polls the count until it drops to lim, bounded
	task wait_count(input logic [5:0] lim, output int k);
		logic [31:0] c;
		k = 0;
		do begin
			rd(wwt_pkg::OFF_COUNT, c);
			k++;
		end while (c[5:0] > lim && k < 300);
		check("count reached", 32'(c[5:0] <= lim), 32'h1);
	endtask

	task print_verdict();
		$display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// scenarios
	task t_regs();
		rd(wwt_pkg::OFF_CONTROL, v);
		check("control reset", v, 32'h003f_0800);
		rd(wwt_pkg::OFF_STATUS, v);
		check("status reset", v, 32'h0000_0000);
		rd(wwt_pkg::OFF_REFRESH, v);
		check("refresh read", v, 32'h0000_0000);
		rd(8'h14, v);
		check("unmapped read", v, 32'h0000_0000);
		wr(wwt_pkg::OFF_REFRESH, wwt_pkg::REFRESH_KEY);
		check("key while stopped", 32'(sys_reset_req), 32'h0);
		cycles(40);
		rd(wwt_pkg::OFF_COUNT, v);
		check("stopped count", v, 32'h0000_003f);
	endtask

	task t_window();
		// compare 0x3c, prescale 1, irq on; compare kept above 2 for prescale 1
		wr(wwt_pkg::OFF_CONTROL, 32'h003c_0003);
		wr(wwt_pkg::OFF_CONTROL, 32'h0000_0000);
		rd(wwt_pkg::OFF_CONTROL, v);
		check("control locked", v, 32'h003c_0003);
		wr(wwt_pkg::OFF_MASK, 32'h0000_0007);
		wait_count(6'h3c, n);
		rd(wwt_pkg::OFF_STATUS, v);
		check("match flags", v, 32'h0000_0005);
		check("irq raised", 32'(irq), 32'h1);
		wr(wwt_pkg::OFF_MASK, 32'h0000_0000);
		// the level output follows the mask one edge later
		cycles(1);
		check("irq masked", 32'(irq), 32'h0);
		wr(wwt_pkg::OFF_MASK, 32'h0000_0007);
		wr(wwt_pkg::OFF_STATUS, 32'h0000_0000);
		rd(wwt_pkg::OFF_STATUS, v);
		check("status zero write", v, 32'h0000_0005);
		wr(wwt_pkg::OFF_STATUS, 32'h0000_0004);
		rd(wwt_pkg::OFF_STATUS, v);
		check("match cleared", v, 32'h0000_0001);
		wr(wwt_pkg::OFF_STATUS, 32'h0000_0001);
		rd(wwt_pkg::OFF_STATUS, v);
		check("irq flag cleared", v, 32'h0000_0000);
		check("irq dropped", 32'(irq), 32'h0);
		wr(wwt_pkg::OFF_REFRESH, 32'h0000_5aa4);
		check("wrong key reset", 32'(sys_reset_req), 32'h0);
		wr(wwt_pkg::OFF_REFRESH, wwt_pkg::REFRESH_KEY);
		rd(wwt_pkg::OFF_COUNT, v);
		check("reload too early", 32'(v[5:0] == 6'h3f), 32'h0);
		n = 0;
		do begin
			rd(wwt_pkg::OFF_COUNT, v);
			n++;
		end while (v[5:0] != 6'h3f && n < 12);
		check("reload seen", v, 32'h0000_003f);
		check("in-window refresh", 32'(sys_reset_req), 32'h0);
		// hold stops counting while debug ignore is clear
		cpu_debug_halt <= 1'b1;
		cycles(10);
		rd(wwt_pkg::OFF_COUNT, v);
		cycles(40);
		rd(wwt_pkg::OFF_COUNT, w);
		check("halted count", w, v);
		cpu_debug_halt <= 1'b0;
		n = 0;
		while (sys_reset_req !== 1'b1 && n < 400) begin
			@(posedge clk);
			n++;
		end
		check("timeout reset", 32'(sys_reset_req), 32'h1);
		rd(wwt_pkg::OFF_COUNT, v);
		check("count at zero", v, 32'h0000_0000);
		do_reset();
		rd(wwt_pkg::OFF_STATUS, v);
		check("reset flag kept", v, 32'h0000_0002);
		wr(wwt_pkg::OFF_STATUS, 32'h0000_0002);
		rd(wwt_pkg::OFF_STATUS, v);
		check("reset flag cleared", v, 32'h0000_0000);
	endtask

	task t_early();
		wr(wwt_pkg::OFF_CONTROL, 32'h003c_0001);
		check("early before", 32'(sys_reset_req), 32'h0);
		wr(wwt_pkg::OFF_REFRESH, wwt_pkg::REFRESH_KEY);
		check("early refresh reset", 32'(sys_reset_req), 32'h1);
		do_reset();
	endtask

	task t_prescale();
		// prescale code 2 with debug ignore set: four ticks per step, halt has no effect
		cpu_debug_halt <= 1'b1;
		wr(wwt_pkg::OFF_CONTROL, 32'h803c_0201);
		wait_count(6'h3d, n);
		wait_count(6'h3c, n);
		check("prescale span", 32'(n >= 7 && n <= 9), 32'h1);
		// irq enable is clear here, and the flag from the early reset is still kept
		rd(wwt_pkg::OFF_STATUS, v);
		check("match without irq enable", v, 32'h0000_0006);
		cpu_debug_halt <= 1'b0;
		do_reset();
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence and hang guard
	initial begin
		cycles(12);
		rst <= 1'b0;
		por_rst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_window();
		t_early();
		t_prescale();
		print_verdict();
	end

	// whole run needs well under a thousand cycles, so this margin is generous
	initial begin
		cycles(20000);
		n_mismatch++;
		print_verdict();
	end
endmodule
